// ===== ccs_pkg.sv
// Shared types and constants for the common command and status block
package ccs_pkg;

  // Decoded common command opcodes from the message parser
  typedef enum logic [3:0] {
    CCS_OP_IDNQ = 4'b0000,
    CCS_OP_RST  = 4'b0001,
    CCS_OP_TSTQ = 4'b0010,
    CCS_OP_OPC  = 4'b0011,
    CCS_OP_OPCQ = 4'b0100,
    CCS_OP_WAI  = 4'b0101,
    CCS_OP_CLS  = 4'b0110,
    CCS_OP_ESE  = 4'b0111,
    CCS_OP_ESEQ = 4'b1000,
    CCS_OP_ESRQ = 4'b1001,
    CCS_OP_PSC  = 4'b1010,
    CCS_OP_PSCQ = 4'b1011
  } ccs_op_t;

  // Kind of response handed to the output queue
  typedef enum logic [2:0] {
    CCS_RSP_IDN = 3'b000,
    CCS_RSP_TST = 3'b001,
    CCS_RSP_OPC = 3'b010,
    CCS_RSP_ESE = 3'b011,
    CCS_RSP_ESR = 3'b100,
    CCS_RSP_PSC = 3'b101
  } ccs_rsp_kind_t;

  typedef enum logic [1:0] {
    CCS_ST_IDLE = 2'b00,
    CCS_ST_WAIT = 2'b01,
    CCS_ST_TEST = 2'b10,
    CCS_ST_RESP = 2'b11
  } ccs_state_t;

  // One command unit: opcode, numeric argument, last unit of its message
  typedef struct packed {
    ccs_op_t op;
    logic [15:0] arg;
    logic msg_last;
  } ccs_cmd_t;

  // One response: kind, signed value, and auxiliary field (serial for identity)
  typedef struct packed {
    ccs_rsp_kind_t kind;
    logic [15:0] value;
    logic [15:0] aux;
  } ccs_rsp_t;

  // Event register bit positions
  localparam int unsigned EV_OPC = 0;
  localparam int unsigned EV_QYE = 2;
  localparam int unsigned EV_EXE = 4;
  localparam int unsigned EV_CME = 5;
  localparam int unsigned EV_PON = 7;
  localparam int unsigned EV_W = 8;
  localparam logic [7:0] EV_USED_MASK = 8'hB5;
  localparam int unsigned STB_ESB_BIT = 5;

  // Reset values and fixed answers
  localparam logic [7:0] ESE_RST_VAL = 8'h00;
  localparam logic [7:0] ESR_RST_VAL = 8'h00;
  localparam logic PSC_RST_VAL = 1'b0;
  localparam logic [15:0] ARG_MAX_VAL = 16'h00FF;
  localparam logic [15:0] TST_PASS_VAL = 16'h0000;
  localparam logic [15:0] TST_FAIL_VAL = 16'hFEB6;
  localparam logic [15:0] OPCQ_VAL = 16'h0001;
  localparam logic [15:0] SERIAL_VAL = 16'h0000;

endpackage

// ===== ccs_event_latch.sv
// Sticky standard event latch with enable mask and summary output
`timescale 1ns/1ps
module ccs_event_latch #(
  parameter int unsigned W = 8,
  parameter logic [7:0] USED = 8'hB5
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [W-1:0] set_i,
  input wire logic clear_i,
  input wire logic [W-1:0] mask_i,
  output logic [W-1:0] event_o,
  output logic summary_o
);
  import ccs_pkg::*;

  logic [W-1:0] event_ff;
  logic summary_ff;
  logic [W-1:0] nxt_event;
  wire nxt_summary = |(nxt_event & mask_i);

  if (W != 8) begin : g_bad_width
    $error("ccs_event_latch supports only an eight bit register");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per bit: a set arriving with the clear still lands, so no event is lost
  for (genvar b = 0; b < W; b++) begin : g_bit
    if (USED[b]) begin : g_used
      assign nxt_event[b] = (event_ff[b] & ~clear_i) | set_i[b];
    end else begin : g_unused
      assign nxt_event[b] = 1'b0; // Unused positions always read zero
    end
  end

  // Summary is registered so the status bit is glitch free
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      event_ff <= ESR_RST_VAL;
      summary_ff <= 1'b0;
    end else begin
      event_ff <= nxt_event;
      summary_ff <= nxt_summary;
    end
  end

  assign event_o = event_ff;
  assign summary_o = summary_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_summary_tracks;
    @(posedge clk_i) disable iff (!arst_n_i)
      1'b1 |=> summary_o == |(event_o & $past(mask_i));
  endproperty
  a_summary_tracks: assert property (p_summary_tracks)
    else $error("summary does not match masked events");

  property p_unused_zero;
    @(posedge clk_i) disable iff (!arst_n_i)
      set_i != '0 |=> (event_o & ~USED) == '0;
  endproperty
  a_unused_zero: assert property (p_unused_zero)
    else $error("unused event bit became set");
endmodule

// ===== ccs_common_cmd.sv
// Common command interpreter with standard event status and enable logic
//
// Function
// - Identity query answers maker, model, zero serial and firmware level.
// - A query following the identity query in one message errors, gets no answer.
// - Reset command restores factory defaults except interface settings.
// - Reset command also selects factory initialise as power-up setup.
// - Self-test query answers zero on pass, minus 330 on fail.
// - Operation complete command sets event bit 0 after pending work ends.
// - Operation complete query answers +1 and leaves the event bit alone.
// - Wait command holds all following commands until pending work ends.
// - Clear status empties the event register and device event register.
// - Enable command loads the eight bit mask from argument 0 to 255.
// - Enable bit one passes its event to the summary, zero blocks it.
// - Enable query answers the mask with unused bits reading zero.
// - Event bits: 7 power-on, 5 command, 4 execution, 2 query, 0 complete.
// - Event query answers the register then clears it.
// - Power-on clear flag governs clearing all enable registers at power-up.
// - Clear flag command stores zero to retain, nonzero to clear.
// - Clear flag query answers the stored flag as zero or one.
// - Masked events are ORed onto status byte bit 5.
// - Power-on event bit is set after each power-up.
// - Query errors set event bit 2.
`timescale 1ns/1ps
module ccs_common_cmd #(
  parameter int unsigned FW_LEVEL = 100,
  parameter logic [15:0] MFR_ID = 16'h00A5, // Arbitrary value
  parameter logic [15:0] MODEL_ID = 16'h005A // Arbitrary value
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic cmd_valid_i,
  input wire ccs_pkg::ccs_cmd_t cmd_i,
  output logic cmd_ready_o,
  output logic rsp_valid_o,
  output ccs_pkg::ccs_rsp_t rsp_o,
  output logic [15:0] rsp_mfr_o,
  output logic [15:0] rsp_model_o,
  input wire logic rsp_ready_i,
  input wire logic cmd_err_i,
  input wire logic exec_err_i,
  input wire logic ops_busy_i,
  output logic selftest_start_o,
  input wire logic selftest_done_i,
  input wire logic selftest_pass_i,
  output logic settings_rst_o,
  output logic factory_init_power_setup_o,
  input wire logic power_setup_last_i,
  output logic dev_event_clr_o,
  input wire logic [7:0] nv_ese_i,
  input wire logic nv_psc_i,
  output logic enables_clr_o,
  output logic [7:0] ese_o,
  output logic psc_o,
  output logic esb_o,
  output logic [7:0] esr_o
);
  import ccs_pkg::*;

  if (FW_LEVEL > 65535) begin : g_bad_fw
    $error("FW_LEVEL does not fit the sixteen bit response value");
  end

  localparam logic [15:0] FW_VAL = FW_LEVEL[15:0];

  ccs_state_t state_ff, nxt_state;
  ccs_op_t wait_op_ff;
  ccs_rsp_t rsp_ff;
  logic [7:0] ese_ff;
  logic psc_ff;
  logic init_setup_ff;
  logic idn_seen_ff;
  logic boot_ff;
  logic settings_rst_ff;
  logic dev_clr_ff;
  logic tst_start_ff;
  logic enables_clr_ff;
  logic [7:0] event_q;
  logic esb_q;

  ////////////////////////////////////////////////////////////////////////////
  // Command decode
  wire take = cmd_valid_i & cmd_ready_o;
  wire is_query = cmd_i.op inside {CCS_OP_IDNQ, CCS_OP_TSTQ, CCS_OP_OPCQ,
                                   CCS_OP_ESEQ, CCS_OP_ESRQ, CCS_OP_PSCQ};
  wire blocked = take & is_query & idn_seen_ff;
  wire run = take & ~blocked;
  wire op_idn = run & (cmd_i.op == CCS_OP_IDNQ);
  wire op_rst = run & (cmd_i.op == CCS_OP_RST);
  wire op_tst = run & (cmd_i.op == CCS_OP_TSTQ);
  wire op_sync = run & (cmd_i.op inside {CCS_OP_OPC, CCS_OP_OPCQ, CCS_OP_WAI});
  wire op_cls = run & (cmd_i.op == CCS_OP_CLS);
  wire op_ese = run & (cmd_i.op == CCS_OP_ESE);
  wire op_eseq = run & (cmd_i.op == CCS_OP_ESEQ);
  wire op_esrq = run & (cmd_i.op == CCS_OP_ESRQ);
  wire op_psc = run & (cmd_i.op == CCS_OP_PSC);
  wire op_pscq = run & (cmd_i.op == CCS_OP_PSCQ);
  wire arg_bad = cmd_i.arg > ARG_MAX_VAL;
  wire ese_load = op_ese & ~arg_bad;
  wire ese_range_err = op_ese & arg_bad;

  // Pending work drains; only then do the synchronising commands finish
  wire ops_done = (state_ff == CCS_ST_WAIT) & ~ops_busy_i;
  wire opc_fire = ops_done & (wait_op_ff == CCS_OP_OPC);
  wire opcq_fire = ops_done & (wait_op_ff == CCS_OP_OPCQ);
  wire tst_fire = (state_ff == CCS_ST_TEST) & selftest_done_i;
  wire rsp_load = op_idn | op_eseq | op_esrq | op_pscq | opcq_fire | tst_fire;

  // Event sources; query errors from the identity rule land on bit 2
  wire [7:0] ev_set = {boot_ff, 1'b0, cmd_err_i, exec_err_i | ese_range_err, 1'b0,
                       blocked, 1'b0, opc_fire};
  wire ev_clear = op_cls | op_esrq;

  ccs_event_latch #(
    .W(EV_W),
    .USED(EV_USED_MASK)
  ) u_event (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .set_i(ev_set),
    .clear_i(ev_clear),
    .mask_i(ese_ff),
    .event_o(event_q),
    .summary_o(esb_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: new commands are held off while waiting, testing or answering
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      CCS_ST_IDLE: begin
        if (op_sync) begin
          nxt_state = CCS_ST_WAIT;
        end else if (op_tst) begin
          nxt_state = CCS_ST_TEST;
        end else if (rsp_load) begin
          nxt_state = CCS_ST_RESP;
        end
      end
      CCS_ST_WAIT: begin
        if (opcq_fire) begin
          nxt_state = CCS_ST_RESP;
        end else if (ops_done) begin
          nxt_state = CCS_ST_IDLE;
        end
      end
      CCS_ST_TEST: begin
        if (tst_fire) begin
          nxt_state = CCS_ST_RESP;
        end
      end
      CCS_ST_RESP: begin
        if (rsp_ready_i) begin
          nxt_state = CCS_ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_ff <= CCS_ST_IDLE;
      wait_op_ff <= CCS_OP_WAI;
    end else begin
      state_ff <= nxt_state;
      if (op_sync) begin
        wait_op_ff <= cmd_i.op;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Response register: held until the output queue takes it
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rsp_ff <= '{kind: CCS_RSP_IDN, value: 16'h0000, aux: 16'h0000};
    end else if (op_idn) begin
      rsp_ff <= '{kind: CCS_RSP_IDN, value: FW_VAL, aux: SERIAL_VAL};
    end else if (tst_fire) begin
      rsp_ff <= '{kind: CCS_RSP_TST, aux: 16'h0000,
                  value: selftest_pass_i ? TST_PASS_VAL : TST_FAIL_VAL};
    end else if (opcq_fire) begin
      rsp_ff <= '{kind: CCS_RSP_OPC, value: OPCQ_VAL, aux: 16'h0000};
    end else if (op_eseq) begin
      rsp_ff <= '{kind: CCS_RSP_ESE, value: {8'h00, ese_ff & EV_USED_MASK},
                  aux: 16'h0000};
    end else if (op_esrq) begin
      rsp_ff <= '{kind: CCS_RSP_ESR, value: {8'h00, event_q}, aux: 16'h0000};
    end else if (op_pscq) begin
      rsp_ff <= '{kind: CCS_RSP_PSC, value: {15'h0000, psc_ff}, aux: 16'h0000};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Identity tracking: any later query in the same message is refused
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      idn_seen_ff <= 1'b0;
    end else if (take) begin
      idn_seen_ff <= (idn_seen_ff | op_idn) & ~cmd_i.msg_last;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Enable mask and clear flag. Reset cannot load a port value, so the
  // retained copies are picked up in the first clocked cycle after release.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      boot_ff <= 1'b1;
      ese_ff <= ESE_RST_VAL;
      psc_ff <= PSC_RST_VAL;
      enables_clr_ff <= 1'b0;
    end else begin
      boot_ff <= 1'b0;
      enables_clr_ff <= boot_ff & nv_psc_i;
      if (boot_ff) begin
        ese_ff <= nv_psc_i ? ESE_RST_VAL : nv_ese_i;
        psc_ff <= nv_psc_i;
      end else begin
        if (ese_load) begin
          ese_ff <= cmd_i.arg[7:0];
        end
        if (op_psc) begin
          psc_ff <= cmd_i.arg != 16'h0000;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset command side effects; the interface settings live outside and
  // are not touched, only the power-up choice flips to factory initialise.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      settings_rst_ff <= 1'b0;
      init_setup_ff <= 1'b0;
      dev_clr_ff <= 1'b0;
      tst_start_ff <= 1'b0;
    end else begin
      settings_rst_ff <= op_rst;
      dev_clr_ff <= op_cls;
      tst_start_ff <= op_tst;
      if (op_rst) begin
        init_setup_ff <= 1'b1;
      end else if (power_setup_last_i) begin
        init_setup_ff <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign cmd_ready_o = (state_ff == CCS_ST_IDLE) & ~boot_ff;
  assign rsp_valid_o = state_ff == CCS_ST_RESP;
  assign rsp_o = rsp_ff;
  assign rsp_mfr_o = MFR_ID;
  assign rsp_model_o = MODEL_ID;
  assign selftest_start_o = tst_start_ff;
  assign settings_rst_o = settings_rst_ff;
  assign factory_init_power_setup_o = init_setup_ff;
  assign dev_event_clr_o = dev_clr_ff;
  assign enables_clr_o = enables_clr_ff;
  assign ese_o = ese_ff;
  assign psc_o = psc_ff;
  assign esb_o = esb_q; // Status byte bit 5
  assign esr_o = event_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_idn_taken;
    op_idn;
  endsequence

  property p_idn_answer;
    @(posedge clk_i) disable iff (!arst_n_i)
      s_idn_taken |=> rsp_valid_o && rsp_o.kind == CCS_RSP_IDN && rsp_o.aux == 16'h0000
        && rsp_o.value == FW_VAL;
  endproperty
  a_idn_answer: assert property (p_idn_answer)
    else $error("identity answer wrong");

  property p_after_idn;
    @(posedge clk_i) disable iff (!arst_n_i)
      blocked |=> event_q[EV_QYE] && !rsp_valid_o;
  endproperty
  a_after_idn: assert property (p_after_idn)
    else $error("query after identity not refused");

  property p_rst_effect;
    @(posedge clk_i) disable iff (!arst_n_i)
      op_rst |=> settings_rst_o && factory_init_power_setup_o ##1 !settings_rst_o;
  endproperty
  a_rst_effect: assert property (p_rst_effect)
    else $error("reset command effects wrong");

  property p_tst_fail;
    @(posedge clk_i) disable iff (!arst_n_i)
      tst_fire && !selftest_pass_i |=> rsp_valid_o && rsp_o.value == TST_FAIL_VAL;
  endproperty
  a_tst_fail: assert property (p_tst_fail)
    else $error("self-test failure value wrong");

  sequence s_opc_wait;
    op_sync && cmd_i.op == CCS_OP_OPC ##1 ops_busy_i [*2];
  endsequence

  property p_opc_held;
    @(posedge clk_i) disable iff (!arst_n_i)
      s_opc_wait |-> !opc_fire;
  endproperty
  a_opc_held: assert property (p_opc_held)
    else $error("completion flagged while busy");

  property p_opc_sets;
    @(posedge clk_i) disable iff (!arst_n_i)
      opc_fire |=> event_q[EV_OPC];
  endproperty
  a_opc_sets: assert property (p_opc_sets)
    else $error("completion bit not set");

  property p_opcq_no_bit;
    @(posedge clk_i) disable iff (!arst_n_i)
      opcq_fire |-> !ev_set[EV_OPC] ##1 rsp_o.value == OPCQ_VAL;
  endproperty
  a_opcq_no_bit: assert property (p_opcq_no_bit)
    else $error("completion query misbehaved");

  property p_wait_holds;
    @(posedge clk_i) disable iff (!arst_n_i)
      state_ff == CCS_ST_WAIT && ops_busy_i |=> !cmd_ready_o;
  endproperty
  a_wait_holds: assert property (p_wait_holds)
    else $error("commands accepted while waiting");

  property p_cls_clears;
    @(posedge clk_i) disable iff (!arst_n_i)
      op_cls && ev_set == 8'h00 |=> event_q == 8'h00 && dev_event_clr_o;
  endproperty
  a_cls_clears: assert property (p_cls_clears)
    else $error("clear status left bits");

  property p_ese_load;
    @(posedge clk_i) disable iff (!arst_n_i)
      ese_load |=> ese_o == $past(cmd_i.arg[7:0]);
  endproperty
  a_ese_load: assert property (p_ese_load)
    else $error("enable mask not loaded");

  property p_esr_read;
    @(posedge clk_i) disable iff (!arst_n_i)
      op_esrq && ev_set == 8'h00 |=> rsp_o.value[7:0] == $past(event_q) && event_q == 8'h00;
  endproperty
  a_esr_read: assert property (p_esr_read)
    else $error("event read did not answer and clear");

  property p_boot_clear;
    @(posedge clk_i) disable iff (!arst_n_i)
      boot_ff && nv_psc_i |=> ese_o == 8'h00 && enables_clr_o && event_q[EV_PON];
  endproperty
  a_boot_clear: assert property (p_boot_clear)
    else $error("power-up clear not applied");
endmodule

// ===== ccs_far_model.sv
// Far-side model: self-test engine answering after a set latency
`timescale 1ns/1ps
module ccs_far_model (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic start_i,
  input wire logic [3:0] lat_i,
  input wire logic pass_i,
  output logic done_o,
  output logic pass_o
);
  logic [3:0] cnt_ff;
  logic busy_ff;
  logic flip_ff;
  // Count down the test time, then pulse done for one cycle
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_ff <= 4'h0;
      busy_ff <= 1'b0;
      done_o <= 1'b0;
      flip_ff <= 1'b0;
    end else begin
      flip_ff <= ~flip_ff;
      done_o <= 1'b0;
      if (start_i) begin
        busy_ff <= 1'b1;
        cnt_ff <= lat_i;
      end else if (busy_ff && cnt_ff == 4'h0) begin
        busy_ff <= 1'b0;
        done_o <= 1'b1;
      end else if (busy_ff) begin
        cnt_ff <= cnt_ff - 4'h1;
      end
    end
  end
  // Result wobbles outside the done cycle so a stale value cannot pass
  assign pass_o = done_o ? pass_i : flip_ff;
endmodule

// ===== ieee4882_common_command_status_tb_top.sv
// Self-checking bench for the common command interpreter
`timescale 1ns/1ps
module ieee4882_common_command_status_tb_top;
  import ccs_pkg::*;
  localparam logic [15:0] MFR = 16'h0123; // Arbitrary value
  localparam logic [15:0] MDL = 16'h0456; // Arbitrary value
  localparam int FW = 100;
  logic clk_i, arst_n_i, cmd_valid_i, cmd_ready_o, rsp_valid_o, rsp_ready_i;
  logic cmd_err_i, exec_err_i, ops_busy_i, st_start, st_done, st_pass;
  logic settings_rst_o, fips_o, power_setup_last_i, dev_event_clr_o;
  logic nv_psc_i, enables_clr_o, psc_o, esb_o, tpass;
  logic [7:0] nv_ese_i, ese_o, esr_o;
  logic [15:0] mfr_o, model_o;
  logic [3:0] tlat;
  logic [31:0] seed = 32'h0000_305A;
  ccs_cmd_t cmd_i;
  ccs_rsp_t rsp_o;
  int fail_count, checks, cyc, n_rst, n_dev, n_en, n_tst, esr_m, ese_m, psc_m, a, n;

  ccs_common_cmd #(.FW_LEVEL(FW), .MFR_ID(MFR), .MODEL_ID(MDL)) u_ccs_common_cmd (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i),
    .cmd_ready_o(cmd_ready_o), .rsp_valid_o(rsp_valid_o), .rsp_o(rsp_o),
    .rsp_mfr_o(mfr_o), .rsp_model_o(model_o), .rsp_ready_i(rsp_ready_i),
    .cmd_err_i(cmd_err_i), .exec_err_i(exec_err_i), .ops_busy_i(ops_busy_i),
    .selftest_start_o(st_start), .selftest_done_i(st_done), .selftest_pass_i(st_pass),
    .settings_rst_o(settings_rst_o), .factory_init_power_setup_o(fips_o),
    .power_setup_last_i(power_setup_last_i), .dev_event_clr_o(dev_event_clr_o),
    .nv_ese_i(nv_ese_i), .nv_psc_i(nv_psc_i), .enables_clr_o(enables_clr_o),
    .ese_o(ese_o), .psc_o(psc_o), .esb_o(esb_o), .esr_o(esr_o));

  ccs_far_model u_ccs_far_model (.clk_i(clk_i), .arst_n_i(arst_n_i), .start_i(st_start),
    .lat_i(tlat), .pass_i(tpass), .done_o(st_done), .pass_o(st_pass));

  // 20 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  // Pulse counters sample mid-cycle, away from the launching edge
  always @(negedge clk_i) begin
    n_rst += (settings_rst_o === 1'b1);
    n_dev += (dev_event_clr_o === 1'b1);
    n_en += (enables_clr_o === 1'b1);
    n_tst += (st_start === 1'b1);
  end

  // Hang guard: the whole run needs well under this many cycles
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      end_sim();
    end
  end

  function automatic int rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return int'(seed[30:0]);
  endfunction

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Offer one command unit and hold it until the block takes it
  task automatic send(input ccs_op_t op, input int arg, input logic last);
    int k;
    @(negedge clk_i);
    cmd_valid_i = 1'b1;
    cmd_i.op = op;
    cmd_i.arg = arg[15:0];
    cmd_i.msg_last = last;
    k = 0;
    while (cmd_ready_o !== 1'b1 && k < 300) begin
      @(negedge clk_i);
      k++;
    end
    if (k == 300) fail_count++; // A refused take is a mismatch, not a silent pass
    @(negedge clk_i);
    cmd_valid_i = 1'b0;
  endtask

  // Wait for a response, stall the queue a little, then accept it
  task automatic get_rsp(input ccs_rsp_kind_t kd, input logic [15:0] v);
    int k;
    k = 0;
    while (rsp_valid_o !== 1'b1 && k < 300) begin
      @(negedge clk_i);
      k++;
    end
    if (k == 300) fail_count++; // Missing answer counts as a mismatch
    repeat (rnd() % 3) @(negedge clk_i);
    chk(16'(rsp_o.kind), 16'(kd));
    chk(rsp_o.value, v);
    if (kd == CCS_RSP_IDN) chk(rsp_o.aux, 16'h0000);
    rsp_ready_i = 1'b1;
    @(negedge clk_i);
    rsp_ready_i = 1'b0;
  endtask

  // Compare status state with the model once the summary lag has passed
  task automatic chk_regs(input string name);
    repeat (3) @(negedge clk_i);
    chk(16'(esr_o), 16'(esr_m));
    chk(16'(ese_o), 16'(ese_m));
    chk(16'(psc_o), 16'(psc_m));
    chk(16'(esb_o), 16'((esr_m & ese_m) != 0));
    $display("test %s done", name);
  endtask

  task automatic do_reset(input logic p);
    @(negedge clk_i);
    arst_n_i = 1'b0;
    nv_psc_i = p;
    nv_ese_i = 8'(rnd());
    repeat (10) @(negedge clk_i);
    arst_n_i = 1'b1;
    repeat (3) @(negedge clk_i);
    esr_m = 128;
    psc_m = p;
    ese_m = p ? 0 : nv_ese_i;
  endtask

  task automatic pulse_err(input logic c);
    @(negedge clk_i);
    cmd_err_i = c;
    exec_err_i = !c;
    @(negedge clk_i);
    cmd_err_i = 1'b0;
    exec_err_i = 1'b0;
  endtask

  initial begin
    {arst_n_i, cmd_valid_i, rsp_ready_i, cmd_err_i, exec_err_i} = '0;
    {ops_busy_i, power_setup_last_i, nv_psc_i, tpass} = '0;
    nv_ese_i = 8'h00;
    tlat = 4'h0;
    cmd_i = '0;
    do_reset(1'b0);
    chk(16'(n_en), 16'h0000);
    chk_regs("power_up");
    send(CCS_OP_ESRQ, 0, 1'b1);
    get_rsp(CCS_RSP_ESR, 16'(esr_m));
    esr_m = 0;
    chk_regs("event_read");
    for (int i = 0; i < 6; i++) begin
      a = (i == 0) ? 255 : (i == 1) ? 0 : rnd() % 256;
      send(CCS_OP_ESE, a, 1'b1);
      ese_m = a;
      send(CCS_OP_ESEQ, 0, 1'b1);
      get_rsp(CCS_RSP_ESE, 16'(a & 181));
    end
    send(CCS_OP_ESE, 300, 1'b1);
    esr_m |= 16;
    chk_regs("mask_range");
    pulse_err(1'b1);
    esr_m |= 32;
    send(CCS_OP_ESE, 32, 1'b1);
    ese_m = 32;
    chk_regs("summary_on");
    send(CCS_OP_ESE, 4, 1'b1);
    ese_m = 4;
    chk_regs("summary_off");
    n = n_dev;
    send(CCS_OP_CLS, 0, 1'b1);
    esr_m = 0;
    chk_regs("clear");
    chk(16'(n_dev), 16'(n + 1));
    send(CCS_OP_IDNQ, 0, 1'b0);
    get_rsp(CCS_RSP_IDN, 16'(FW));
    chk(mfr_o, MFR);
    chk(model_o, MDL);
    send(CCS_OP_ESEQ, 0, 1'b1);
    esr_m |= 4;
    chk_regs("ident_last");
    chk(16'(rsp_valid_o), 16'h0000);
    n = n_rst;
    send(CCS_OP_RST, 0, 1'b1);
    chk_regs("reset_cmd");
    chk(16'(n_rst), 16'(n + 1));
    chk(16'(fips_o), 16'h0001);
    @(negedge clk_i);
    power_setup_last_i = 1'b1;
    @(negedge clk_i);
    power_setup_last_i = 1'b0;
    @(negedge clk_i);
    chk(16'(fips_o), 16'h0000);
    for (int p = 0; p < 2; p++) begin
      tpass = p[0];
      tlat = 4'(rnd() % 8);
      n = n_tst;
      send(CCS_OP_TSTQ, 0, 1'b1);
      get_rsp(CCS_RSP_TST, p ? 16'h0000 : 16'(-330));
      chk(16'(n_tst), 16'(n + 1));
    end
    ops_busy_i = 1'b1;
    send(CCS_OP_OPC, 0, 1'b1);
    repeat (6) @(negedge clk_i);
    chk(16'(esr_o[0]), 16'h0000);
    ops_busy_i = 1'b0;
    esr_m |= 1;
    chk_regs("complete_cmd");
    send(CCS_OP_ESRQ, 0, 1'b1);
    get_rsp(CCS_RSP_ESR, 16'(esr_m));
    esr_m = 0;
    ops_busy_i = 1'b1;
    send(CCS_OP_OPCQ, 0, 1'b1);
    repeat (4) @(negedge clk_i);
    chk(16'(rsp_valid_o), 16'h0000);
    ops_busy_i = 1'b0;
    get_rsp(CCS_RSP_OPC, 16'h0001);
    chk_regs("complete_query");
    ops_busy_i = 1'b1;
    send(CCS_OP_WAI, 0, 1'b1);
    repeat (5) @(negedge clk_i);
    chk(16'(cmd_ready_o), 16'h0000);
    ops_busy_i = 1'b0;
    send(CCS_OP_PSC, 5, 1'b1);
    psc_m = 1;
    send(CCS_OP_PSCQ, 0, 1'b1);
    get_rsp(CCS_RSP_PSC, 16'h0001);
    send(CCS_OP_PSC, 0, 1'b1);
    psc_m = 0;
    send(CCS_OP_PSCQ, 0, 1'b1);
    get_rsp(CCS_RSP_PSC, 16'h0000);
    chk_regs("clear_flag");
    n = n_en;
    do_reset(1'b1);
    chk(16'(n_en), 16'(n + 1));
    chk_regs("power_clear");
    end_sim();
  end
endmodule
